// file: logic/cct_cfg.svh
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH

// Register indices; the byte address is four times the index
`define CCT_IDX_CTRL_TWO 7'h47
`define CCT_IDX_CTRL_ONE 7'h48
`define CCT_IDX_FLAGS 7'h49
`define CCT_IDX_CAP1_HI 7'h4A
`define CCT_IDX_CAP1_LO 7'h4B
`define CCT_IDX_CMP1_HI 7'h4C
`define CCT_IDX_CMP1_LO 7'h4D
`define CCT_IDX_CNT_HI 7'h4E
`define CCT_IDX_CNT_LO 7'h4F
`define CCT_IDX_ALT_HI 7'h50
`define CCT_IDX_ALT_LO 7'h51
`define CCT_IDX_CAP2_HI 7'h52
`define CCT_IDX_CAP2_LO 7'h53
`define CCT_IDX_CMP2_HI 7'h54
`define CCT_IDX_CMP2_LO 7'h55

// Flag vector positions (status bit = position + 3)
`define CCT_FLAG_BASE 3
`define CCT_FLAG_CAP1 4
`define CCT_FLAG_CMP1 3
`define CCT_FLAG_OVF 2
`define CCT_FLAG_CAP2 1
`define CCT_FLAG_CMP2 0
`define CCT_FREEZE_BIT 2

// Reset values, counter top and one-pulse capture value
`define CCT_CTRL_RST 8'h00
`define CCT_CMP_RST 16'h8000
`define CCT_CNT_RST 16'hFFFC
`define CCT_CNT_TOP 16'hFFFF
`define CCT_OPM_CAPTURE 16'hFFFD

// Prescaler masks: tick when the prescaler's masked bits are all ones
`define CCT_DIV2_MASK 3'h1
`define CCT_DIV4_MASK 3'h3
`define CCT_DIV8_MASK 3'h7

`endif

// file: logic/cct_pkg.sv
package cct_pkg;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_level_two;
    logic force_level_one;
    logic out_level_two;
    logic capture_one_edge;
    logic out_level_one;
  } cct_ctrl_one_s;

  typedef struct packed {
    logic compare_one_pin_enable;
    logic compare_two_pin_enable;
    logic one_pulse_select;
    logic pwm_select;
    logic [1:0] clock_select_field;
    logic capture_two_edge;
    logic ext_clock_edge;
  } cct_ctrl_two_s;

  typedef enum logic [1:0] {
    CCT_CLK_DIV4,
    CCT_CLK_DIV2,
    CCT_CLK_DIV8,
    CCT_CLK_EXT
  } cct_clk_e;

  typedef enum logic [1:0] {
    CCT_MODE_NORMAL,
    CCT_MODE_ONE_PULSE,
    CCT_MODE_PWM
  } cct_mode_e;

  typedef struct packed {
    logic capture_one_pin;
    logic capture_two_pin;
    logic ext_count_pin;
  } cct_pins_in_s;

endpackage

// file: logic/cct_timer.sv
`timescale 1ns/10ps
`include "cct_cfg.svh"
// ------------------------------------------------------------
// Summary of operation
// - All timer events share one request, gated by enables and global mask.
// - In PWM mode neither compare flag is set.
// - Control one bit 7 enables requests from either capture flag.
// - Control one bit 6 enables requests from either compare flag.
// - Control one bit 5 enables the overflow request.
// - Control one bit 4 forces level two onto compare pin two.
// - Control one bit 3 forces level one onto compare pin one.
// - Level two goes to pin two on match two in normal mode; pin one in pulse modes.
// - Control one bit 1 picks capture one edge: 0 falling, 1 rising.
// - Level one goes to pin one on a match with compare one.
// - Control two bits 7,6 connect compare pins; compares always run.
// - Control two bit 5: capture one edge triggers one pulse on pin one.
// - Control two bit 4: PWM on pin one, width compare one, period two.
// - Control two bits 3,2 pick clock: /4, /2, /8 or external.
// - External clock chosen without external pin stops the counter.
// - Control two bit 1 picks capture two edge: 0 falling, 1 rising.
// - Control two bit 0 picks the external clock counting edge.
// - Status bits 7..3 read only, bit 2 writable, bits 1..0 read zero.
// - Capture one flag: capture or PWM period end; status read, capture one low.
// - Compare one flag: match one in normal mode only; cleared by status read, compare one low.
// - Overflow flag at wrap; status read then counter low, not alternate.
// - Capture two flag: capture two; cleared by status read, capture two low.
// - Compare two flag: match two; cleared by status read, compare two low.
// - Status bit 2 freezes prescaler and counter and turns off both compare output enables.
// - In PWM mode the compare two event reloads the counter with FFFC.
// ------------------------------------------------------------
module cct_timer
  import cct_pkg::*;
#(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cct_pins_in_s pins_in,
  input wire logic global_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic timer_irq,
  output logic wake_from_wait,
  output logic compare_one_pin,
  output logic compare_one_oe,
  output logic compare_two_pin,
  output logic compare_two_oe
);

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  cct_ctrl_one_s ctrl_one_r;
  cct_ctrl_two_s ctrl_two_r;
  logic freeze_r;
  logic [4:0] flag_r;
  logic [4:0] armed_r;
  logic [15:0] cnt_r;
  logic [15:0] cap1_r;
  logic [15:0] cap2_r;
  logic [15:0] cmp1_r;
  logic [15:0] cmp2_r;
  logic [15:0] cmp1_act_r;
  logic [15:0] cmp2_act_r;
  logic cmp1_hold_r;
  logic cmp2_hold_r;
  logic dp_write_r;
  logic [6:0] dp_idx_r;
  logic [31:0] hrdata_r;
  logic [6:0] ap_idx;
  logic ap_take;
  logic ap_read;
  logic dp_wr;
  logic [7:0] rd_byte;

  assign ap_idx = haddr[8:2];
  assign ap_take = hsel & htrans[1] & hready;
  assign ap_read = ap_take & ~hwrite;
  assign dp_wr = dp_write_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_r <= 1'b0;
      dp_idx_r <= 7'h00;
    end else begin
      dp_write_r <= ap_take & hwrite;
      dp_idx_r <= ap_idx;
    end
  end

  // Status read returns flags, freeze bit, and zeros below
  always_comb begin
    rd_byte = 8'h00;
    unique case (ap_idx)
      `CCT_IDX_CTRL_ONE: rd_byte = ctrl_one_r;
      `CCT_IDX_CTRL_TWO: rd_byte = ctrl_two_r;
      `CCT_IDX_FLAGS: rd_byte = {flag_r, freeze_r, 2'b00};
      `CCT_IDX_CAP1_HI: rd_byte = cap1_r[15:8];
      `CCT_IDX_CAP1_LO: rd_byte = cap1_r[7:0];
      `CCT_IDX_CMP1_HI: rd_byte = cmp1_r[15:8];
      `CCT_IDX_CMP1_LO: rd_byte = cmp1_r[7:0];
      `CCT_IDX_CNT_HI: rd_byte = cnt_r[15:8];
      `CCT_IDX_CNT_LO: rd_byte = cnt_r[7:0];
      `CCT_IDX_ALT_HI: rd_byte = cnt_r[15:8];
      `CCT_IDX_ALT_LO: rd_byte = cnt_r[7:0];
      `CCT_IDX_CAP2_HI: rd_byte = cap2_r[15:8];
      `CCT_IDX_CAP2_LO: rd_byte = cap2_r[7:0];
      `CCT_IDX_CMP2_HI: rd_byte = cmp2_r[15:8];
      `CCT_IDX_CMP2_LO: rd_byte = cmp2_r[7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ap_read) begin
      hrdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one_r <= cct_ctrl_one_s'(`CCT_CTRL_RST);
      ctrl_two_r <= cct_ctrl_two_s'(`CCT_CTRL_RST);
      freeze_r <= 1'b0;
    end else if (dp_wr) begin
      if (dp_idx_r == `CCT_IDX_CTRL_ONE) begin
        ctrl_one_r <= cct_ctrl_one_s'(hwdata[7:0]);
      end
      if (dp_idx_r == `CCT_IDX_CTRL_TWO) begin
        ctrl_two_r <= cct_ctrl_two_s'(hwdata[7:0]);
      end
      if (dp_idx_r == `CCT_IDX_FLAGS) begin
        freeze_r <= hwdata[`CCT_FREEZE_BIT];
      end
    end
  end

  // Compare values; a high-byte write holds the compare off until the low byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp1_r <= `CCT_CMP_RST;
      cmp2_r <= `CCT_CMP_RST;
      cmp1_hold_r <= 1'b0;
      cmp2_hold_r <= 1'b0;
    end else if (dp_wr) begin
      unique case (dp_idx_r)
        `CCT_IDX_CMP1_HI: begin
          cmp1_r[15:8] <= hwdata[7:0];
          cmp1_hold_r <= 1'b1;
        end
        `CCT_IDX_CMP1_LO: begin
          cmp1_r[7:0] <= hwdata[7:0];
          cmp1_hold_r <= 1'b0;
        end
        `CCT_IDX_CMP2_HI: begin
          cmp2_r[15:8] <= hwdata[7:0];
          cmp2_hold_r <= 1'b1;
        end
        `CCT_IDX_CMP2_LO: begin
          cmp2_r[7:0] <= hwdata[7:0];
          cmp2_hold_r <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Mode and clock selection
  // ------------------------------------------------------------
  cct_mode_e mode;
  cct_clk_e clk_sel;
  logic [2:0] presc_r;
  logic [2:0] presc_mask;
  logic ext_prev_r;
  logic cap1_prev_r;
  logic cap2_prev_r;
  logic ext_edge;
  logic cap1_edge;
  logic cap2_edge;
  logic run;
  logic tick;

  // PWM wins over one-pulse when both are selected
  always_comb begin
    if (ctrl_two_r.pwm_select) begin
      mode = CCT_MODE_PWM;
    end else if (ctrl_two_r.one_pulse_select) begin
      mode = CCT_MODE_ONE_PULSE;
    end else begin
      mode = CCT_MODE_NORMAL;
    end
  end

  assign clk_sel = cct_clk_e'(ctrl_two_r.clock_select_field);
  assign run = ~freeze_r & ~halt_mode;

  always_comb begin
    presc_mask = `CCT_DIV4_MASK;
    unique case (clk_sel)
      CCT_CLK_DIV4: presc_mask = `CCT_DIV4_MASK;
      CCT_CLK_DIV2: presc_mask = `CCT_DIV2_MASK;
      CCT_CLK_DIV8: presc_mask = `CCT_DIV8_MASK;
      CCT_CLK_EXT: presc_mask = `CCT_DIV8_MASK;
    endcase
  end

  // Input edges; pins are synchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_r <= 1'b0;
      cap1_prev_r <= 1'b0;
      cap2_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= pins_in.ext_count_pin;
      cap1_prev_r <= pins_in.capture_one_pin;
      cap2_prev_r <= pins_in.capture_two_pin;
    end
  end

  assign ext_edge = ctrl_two_r.ext_clock_edge
                  ? (pins_in.ext_count_pin & ~ext_prev_r)
                  : (~pins_in.ext_count_pin & ext_prev_r);
  assign cap1_edge = ctrl_one_r.capture_one_edge
                   ? (pins_in.capture_one_pin & ~cap1_prev_r)
                   : (~pins_in.capture_one_pin & cap1_prev_r);
  assign cap2_edge = ctrl_two_r.capture_two_edge
                   ? (pins_in.capture_two_pin & ~cap2_prev_r)
                   : (~pins_in.capture_two_pin & cap2_prev_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_r <= 3'h0;
    end else if (run) begin
      presc_r <= presc_r + 3'h1;
    end
  end

  // External selection without the pin gives no tick at all
  assign tick = run & ((clk_sel == CCT_CLK_EXT)
              ? (HAS_EXT_CLK & ext_edge)
              : ((presc_r & presc_mask) == presc_mask));

  // ------------------------------------------------------------
  // Counter, compare and capture
  // ------------------------------------------------------------
  logic cnt_reset;
  logic opm_trig;
  logic hit1;
  logic hit2;
  logic pwm_end;
  logic wrap;

  assign cnt_reset = dp_wr & ((dp_idx_r == `CCT_IDX_CNT_LO) | (dp_idx_r == `CCT_IDX_ALT_LO));
  assign opm_trig = (mode == CCT_MODE_ONE_PULSE) & cap1_edge & run;
  assign hit1 = tick & ~cmp1_hold_r & (cnt_r == cmp1_act_r);
  assign hit2 = tick & ~cmp2_hold_r & (cnt_r == cmp2_act_r);
  assign pwm_end = hit2 & (mode == CCT_MODE_PWM);
  assign wrap = tick & ~pwm_end & (cnt_r == `CCT_CNT_TOP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= `CCT_CNT_RST;
    end else if (cnt_reset | opm_trig) begin
      cnt_r <= `CCT_CNT_RST;
    end else if (pwm_end) begin
      cnt_r <= `CCT_CNT_RST;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // PWM takes new compare values only at the end of a period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp1_act_r <= `CCT_CMP_RST;
      cmp2_act_r <= `CCT_CMP_RST;
    end else if (mode != CCT_MODE_PWM || pwm_end) begin
      cmp1_act_r <= cmp1_r;
      cmp2_act_r <= cmp2_r;
    end
  end

  // Capture one pin is not a capture source in the pulse modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap1_r <= 16'h0000;
      cap2_r <= 16'h0000;
    end else begin
      if (opm_trig) begin
        cap1_r <= `CCT_OPM_CAPTURE;
      end else if (cap1_edge && mode == CCT_MODE_NORMAL) begin
        cap1_r <= cnt_r;
      end
      if (cap2_edge) begin
        cap2_r <= cnt_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Flags with two-step clear
  // ------------------------------------------------------------
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic ap_lo;
  logic dp_lo;
  logic status_rd;

  always_comb begin
    flag_set = 5'h00;
    flag_set[`CCT_FLAG_CAP1] = (cap1_edge & (mode == CCT_MODE_NORMAL))
                             | opm_trig | pwm_end;
    flag_set[`CCT_FLAG_CMP1] = hit1 & (mode == CCT_MODE_NORMAL);
    flag_set[`CCT_FLAG_OVF] = wrap;
    flag_set[`CCT_FLAG_CAP2] = cap2_edge;
    flag_set[`CCT_FLAG_CMP2] = hit2 & (mode != CCT_MODE_PWM);
  end

  assign status_rd = ap_read & (ap_idx == `CCT_IDX_FLAGS);
  assign ap_lo = ap_take;
  assign dp_lo = dp_wr;

  // Either a read (address phase) or a write (data phase) counts as access
  always_comb begin
    flag_clr = 5'h00;
    flag_clr[`CCT_FLAG_CAP1] = (ap_lo & ~hwrite & ap_idx == `CCT_IDX_CAP1_LO)
                             | (dp_lo & dp_idx_r == `CCT_IDX_CAP1_LO);
    flag_clr[`CCT_FLAG_CMP1] = (ap_lo & ~hwrite & ap_idx == `CCT_IDX_CMP1_LO)
                             | (dp_lo & dp_idx_r == `CCT_IDX_CMP1_LO);
    flag_clr[`CCT_FLAG_OVF] = (ap_lo & ~hwrite & ap_idx == `CCT_IDX_CNT_LO)
                            | (dp_lo & dp_idx_r == `CCT_IDX_CNT_LO);
    flag_clr[`CCT_FLAG_CAP2] = (ap_lo & ~hwrite & ap_idx == `CCT_IDX_CAP2_LO)
                             | (dp_lo & dp_idx_r == `CCT_IDX_CAP2_LO);
    flag_clr[`CCT_FLAG_CMP2] = (ap_lo & ~hwrite & ap_idx == `CCT_IDX_CMP2_LO)
                             | (dp_lo & dp_idx_r == `CCT_IDX_CMP2_LO);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_r[gi] <= 1'b0;
          armed_r[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flag_r[gi] <= 1'b1;
          armed_r[gi] <= armed_r[gi] | status_rd;
        end else if (flag_clr[gi] && armed_r[gi]) begin
          flag_r[gi] <= 1'b0;
          armed_r[gi] <= 1'b0;
        end else if (status_rd && flag_r[gi]) begin
          armed_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Compare outputs
  // ------------------------------------------------------------
  logic lvl1_r;
  logic lvl2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl1_r <= 1'b0;
    end else if (ctrl_one_r.force_level_one) begin
      lvl1_r <= ctrl_one_r.out_level_one;
    end else if (hit1 && mode != CCT_MODE_NORMAL && !cmp1_hold_r) begin
      lvl1_r <= ctrl_one_r.out_level_one;
    end else if (opm_trig || pwm_end) begin
      lvl1_r <= ctrl_one_r.out_level_two;
    end else if (hit1) begin
      lvl1_r <= ctrl_one_r.out_level_one;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl2_r <= 1'b0;
    end else if (ctrl_one_r.force_level_two) begin
      lvl2_r <= ctrl_one_r.out_level_two;
    end else if (hit2 && mode == CCT_MODE_NORMAL) begin
      lvl2_r <= ctrl_one_r.out_level_two;
    end
  end

  assign compare_one_pin = lvl1_r;
  assign compare_two_pin = lvl2_r;
  assign compare_one_oe = ctrl_two_r.compare_one_pin_enable & ~freeze_r;
  assign compare_two_oe = ctrl_two_r.compare_two_pin_enable & ~freeze_r;

  // ------------------------------------------------------------
  // Shared request and wake
  // ------------------------------------------------------------
  logic irq_cap;
  logic irq_cmp;
  logic irq_ovf;

  assign irq_cap = ctrl_one_r.capture_irq_enable
                 & (flag_r[`CCT_FLAG_CAP1] | flag_r[`CCT_FLAG_CAP2]);
  assign irq_cmp = ctrl_one_r.compare_irq_enable
                 & (flag_r[`CCT_FLAG_CMP1] | flag_r[`CCT_FLAG_CMP2]);
  assign irq_ovf = ctrl_one_r.overflow_irq_enable & flag_r[`CCT_FLAG_OVF];
  assign timer_irq = (irq_cap | irq_cmp | irq_ovf) & ~global_irq_mask;
  assign wake_from_wait = timer_irq & wait_mode & ~halt_mode;

endmodule

// file: testbench/cct_checker.sv
`timescale 1ns/10ps
`include "cct_cfg.svh"
module cct_checker
  import cct_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic global_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic timer_irq,
  input wire logic wake_from_wait,
  input wire logic compare_one_pin,
  input wire logic compare_one_oe,
  input wire logic compare_two_pin,
  input wire logic compare_two_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----
  // Bus phases
  // ----
  sequence s_rd(logic [6:0] ix);
    hsel && htrans[1] && hready && !hwrite && haddr[8:2] == ix;
  endsequence
  sequence s_wr(logic [6:0] ix);
    hsel && htrans[1] && hready && hwrite && haddr[8:2] == ix;
  endsequence

  property p_irq_mask;
    global_irq_mask |-> !timer_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("timer request while masked");
  property p_wake;
    wake_from_wait == (timer_irq && wait_mode && !halt_mode);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake output wrong");
  property p_rsv_zero;
    s_rd(`CCT_IDX_FLAGS) |=> hrdata[1:0] == 2'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved status bits not zero");
  property p_irq_cause;
    s_rd(`CCT_IDX_FLAGS) |=> hrdata[7:3] != 5'h00 || !$past(timer_irq);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("timer request with no flag set");
  property p_frz_oe;
    s_rd(`CCT_IDX_FLAGS) ##1 hrdata[2] |-> !compare_one_oe && !compare_two_oe;
  endproperty
  a_frz_oe: assert property (p_frz_oe)
    else $error("compare pin driven while frozen");
  property p_oe1_off;
    s_wr(`CCT_IDX_CTRL_TWO) ##1 !hwdata[7] |=> !compare_one_oe;
  endproperty
  a_oe1_off: assert property (p_oe1_off)
    else $error("pin one driven while disabled");
  property p_oe2_off;
    s_wr(`CCT_IDX_CTRL_TWO) ##1 !hwdata[6] |=> !compare_two_oe;
  endproperty
  a_oe2_off: assert property (p_oe2_off)
    else $error("pin two driven while disabled");
  property p_force1;
    s_wr(`CCT_IDX_CTRL_ONE) ##1 (hwdata[3] && hwdata[0]) ##1 compare_one_oe
      |-> ##[0:2] compare_one_pin;
  endproperty
  a_force1: assert property (p_force1)
    else $error("forced level one missing");
  property p_force2;
    s_wr(`CCT_IDX_CTRL_ONE) ##1 (hwdata[4] && hwdata[2]) ##1 compare_two_oe
      |-> ##[0:2] compare_two_pin;
  endproperty
  a_force2: assert property (p_force2)
    else $error("forced level two missing");
endmodule

bind cct_timer cct_checker i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .global_irq_mask, .wait_mode, .halt_mode, .timer_irq, .wake_from_wait,
  .compare_one_pin, .compare_one_oe, .compare_two_pin, .compare_two_oe
);

// file: testbench/cct_pin_model.sv
`timescale 1ns/10ps
module cct_pin_model
  import cct_pkg::*;
(
  input wire logic hclk,
  output cct_pins_in_s pins_in
);
  // Bit 2 capture one, bit 1 capture two, bit 0 external count pin
  initial pins_in = '0;

  // Each level is held long enough to pass the edge detect registers
  task automatic set_pin(input int k, input logic v);
    @(posedge hclk);
    pins_in[k] <= v;
    repeat (6) @(posedge hclk);
  endtask

  // Count clock stands low between bursts
  task automatic ext_pulse(input int n);
    repeat (n) begin
      set_pin(0, 1'h1);
      set_pin(0, 1'h0);
    end
  endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`include "cct_cfg.svh"
module tb_top
  import cct_pkg::*;
;
  localparam logic [6:0] I_C1 = `CCT_IDX_CTRL_ONE, I_C2 = `CCT_IDX_CTRL_TWO;
  localparam logic [6:0] I_FL = `CCT_IDX_FLAGS, I_NL = `CCT_IDX_CNT_LO;
  localparam logic [6:0] I_NH = `CCT_IDX_CNT_HI, I_AL = `CCT_IDX_ALT_LO;
  localparam logic [6:0] I_K1L = `CCT_IDX_CAP1_LO, I_K2L = `CCT_IDX_CAP2_LO;
  localparam logic [6:0] I_M1H = `CCT_IDX_CMP1_HI, I_M1L = `CCT_IDX_CMP1_LO;
  localparam logic [6:0] I_M2H = `CCT_IDX_CMP2_HI, I_M2L = `CCT_IDX_CMP2_LO;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic global_irq_mask = 1'h0, wait_mode = 1'h0, halt_mode = 1'h0;
  logic hreadyout, hresp, timer_irq, wake_from_wait;
  logic compare_one_pin, compare_one_oe, compare_two_pin, compare_two_oe;
  logic [31:0] hrdata, rv, hrdata_nx, rv_nx;
  logic [7:0] b0, b1, n0;
  cct_pins_in_s pins_in;
  int n_fail = 0, num_checks = 0;
  int dv[3] = '{4, 2, 8};

  always #12.5 hclk = ~hclk;

  cct_timer i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pins_in,
    .global_irq_mask, .wait_mode, .halt_mode, .timer_irq, .wake_from_wait,
    .compare_one_pin, .compare_one_oe, .compare_two_pin, .compare_two_oe
  );
  // Same bus, built without the external count pin
  cct_timer #(.HAS_EXT_CLK(1'b0)) i_dut_noext (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdata_nx), .pins_in,
    .global_irq_mask, .wait_mode, .halt_mode, .timer_irq(), .wake_from_wait(),
    .compare_one_pin(), .compare_one_oe(), .compare_two_pin(), .compare_two_oe()
  );
  cct_pin_model i_pins (.hclk, .pins_in);

  // ----
  // Bus and compare helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [6:0] ix, input logic w, input logic [7:0] d);
    hsel <= 1'h1;
    haddr <= {23'h0, ix, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rv = hrdata;
    rv_nx = hrdata_nx;
  endtask
  task automatic wr(input logic [6:0] ix, input logic [7:0] d);
    acc(ix, 1'h1, d);
  endtask
  task automatic rd(input logic [6:0] ix);
    acc(ix, 1'h0, 8'h00);
  endtask
  task automatic rc(input logic [6:0] ix, input logic [7:0] m, input logic [7:0] x);
    rd(ix);
    chk(rv & {24'h0, m}, {24'h0, x});
    chk((rv & 32'hFFFF_FF00) | {31'h0, hresp}, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Mask bits: irq, wake, pin one, oe one, pin two, oe two
  task automatic po(input logic [5:0] m, input logic [5:0] x);
    cyc(2);
    chk({26'h0, m & {timer_irq, wake_from_wait, compare_one_pin, compare_one_oe,
      compare_two_pin, compare_two_oe}}, {26'h0, x});
  endtask
  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    summarize();
  end

  // ----
  // Test sequence
  // ----
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rc(I_C1, 8'hFF, 8'h00);
    rc(I_C2, 8'hFF, 8'h00);
    rc(I_FL, 8'h07, 8'h00);
    rc(I_M1H, 8'hFF, 8'h80);
    rc(I_M2L, 8'hFF, 8'h00);
    rc(7'h00, 8'hFF, 8'h00);
    wr(7'h7F, 8'h55);
    rc(7'h7F, 8'hFF, 8'h00);
    wr(I_FL, 8'h04);
    wr(I_C2, 8'hC0);
    wr(I_NL, 8'h00);
    rc(I_FL, 8'h07, 8'h04);
    cyc(20);
    rc(I_NH, 8'hFF, 8'hFF);
    rc(I_NL, 8'hFF, 8'hFC);
    po(6'h05, 6'h00);
    wr(I_FL, 8'h00);
    for (int c = 0; c < 3; c++) begin
      wr(I_C2, 8'(c << 2));
      rd(I_NL);
      b0 = rv[7:0];
      cyc(62);
      rd(I_NL);
      chk({24'h0, rv[7:0] - b0}, 32'(64 / dv[c]));
    end
    for (int e = 0; e < 2; e++) begin
      wr(I_C2, 8'h0C | 8'(e));
      rd(I_NL);
      b0 = rv[7:0];
      n0 = rv_nx[7:0];
      i_pins.set_pin(0, 1'h1);
      rd(I_NL);
      b1 = rv[7:0];
      i_pins.set_pin(0, 1'h0);
      rd(I_NL);
      chk({24'h0, b1 - b0}, 32'(e));
      chk({24'h0, rv[7:0] - b1}, 32'(1 - e));
      chk({24'h0, rv_nx[7:0]}, {24'h0, n0});
    end
    wr(I_C2, 8'h00);
    wr(I_NL, 8'h00);
    cyc(40);
    wr(I_FL, 8'h04);
    rd(I_NL);
    rc(I_FL, 8'h20, 8'h20);
    rd(I_AL);
    rc(I_FL, 8'h20, 8'h20);
    wr(I_C1, 8'h20);
    wait_mode <= 1'h1;
    po(6'h30, 6'h30);
    halt_mode <= 1'h1;
    po(6'h30, 6'h20);
    global_irq_mask <= 1'h1;
    halt_mode <= 1'h0;
    wait_mode <= 1'h0;
    po(6'h20, 6'h00);
    global_irq_mask <= 1'h0;
    wr(I_C1, 8'h00);
    po(6'h20, 6'h00);
    rd(I_NL);
    rc(I_FL, 8'h20, 8'h00);
    wr(I_FL, 8'h00);
    wr(I_C2, 8'h0C);
    wr(I_NL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      for (int e = 0; e < 2; e++) begin
        if (k == 0) begin
          wr(I_C1, 8'h80 | 8'(e << 1));
        end else begin
          wr(I_C2, 8'h0C | 8'(e << 1));
        end
        i_pins.set_pin(2 - k, e[0]);
        rd(I_FL);
        rd(k == 0 ? I_K1L : I_K2L);
        i_pins.set_pin(2 - k, !e[0]);
        rc(I_FL, k == 0 ? 8'h80 : 8'h10, 8'h00);
        i_pins.set_pin(2 - k, e[0]);
        rc(I_FL, 8'h90, k == 0 ? 8'h80 : 8'h10);
        po(6'h20, 6'h20);
        rc(k == 0 ? I_K1L : I_K2L, 8'hFF, 8'hFC);
        rc(I_FL, 8'h90, 8'h00);
      end
    end
    wr(I_M1H, 8'hFF);
    wr(I_M1L, 8'hFD);
    wr(I_M2H, 8'hFF);
    wr(I_M2L, 8'hFE);
    wr(I_C1, 8'h45);
    wr(I_C2, 8'hCD);
    wr(I_NL, 8'h00);
    i_pins.ext_pulse(3);
    po(6'h3F, 6'h2F);
    rc(I_FL, 8'hF8, 8'h48);
    rc(I_M1L, 8'hFF, 8'hFD);
    rc(I_FL, 8'hF8, 8'h08);
    rd(I_M2L);
    rc(I_FL, 8'hF8, 8'h00);
    wr(I_C1, 8'h18);
    po(6'h0F, 6'h05);
    wr(I_C1, 8'h1D);
    po(6'h0F, 6'h0F);
    wr(I_C1, 8'h04);
    wr(I_C2, 8'h9D);
    wr(I_NL, 8'h00);
    i_pins.ext_pulse(2);
    po(6'h0C, 6'h04);
    i_pins.ext_pulse(1);
    po(6'h0C, 6'h0C);
    rc(I_NL, 8'hFF, 8'hFC);
    rc(I_FL, 8'hF8, 8'h80);
    wr(I_C1, 8'h03);
    i_pins.set_pin(2, 1'h0);
    wr(I_C2, 8'hAD);
    i_pins.set_pin(2, 1'h1);
    po(6'h0C, 6'h04);
    rc(I_K1L, 8'hFF, 8'hFD);
    i_pins.ext_pulse(2);
    po(6'h0C, 6'h0C);
    summarize();
  end
endmodule
